// file: hw/cec_pkg.sv
// Purpose: Shared constants and types for the comparator event control block
// Assumes: 8-bit I/O register port of the host core
// Notes: One control/status register at I/O offset 0x08
package cec_pkg;
	localparam logic [5:0] CEC_CSR_ADDR = 6'h08;
	localparam logic [7:0] CEC_CSR_RESET = 8'h00;
	localparam int CEC_BIT_POWER_OFF = 7;
	localparam int CEC_BIT_BG_SEL = 6;
	localparam int CEC_BIT_RESULT = 5;
	localparam int CEC_BIT_FLAG = 4;
	localparam int CEC_BIT_IRQ_EN = 3;
	localparam int CEC_BIT_RSVD = 2;
	localparam int CEC_BIT_MODE_HI = 1;
	localparam int CEC_BIT_MODE_LO = 0;
	localparam logic [1:0] CEC_MODE_TOGGLE = 2'h0;
	localparam logic [1:0] CEC_MODE_RSVD = 2'h1;
	localparam logic [1:0] CEC_MODE_FALL = 2'h2;
	localparam logic [1:0] CEC_MODE_RISE = 2'h3;

	typedef struct packed {
		logic power_off;
		logic bg_sel;
		logic flag;
		logic irq_en;
		logic [1:0] mode;
	} cec_ctrl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} cec_bus_req_t;
endpackage : cec_pkg

// file: hw/cec_edge_detect.sv
// Purpose: Synchronise the comparator output and detect selected edges
// Assumes: Comparator output is asynchronous to clk_in
// Notes: Reserved mode yields no event
`timescale 1ns/1ps
module cec_edge_detect
	import cec_pkg::*;
(
	input wire logic clk_in, // System clock
	input wire logic sys_rst_in, // Synchronous reset, high
	input wire logic clk_en_in, // Clock enable
	input wire logic raw_in, // Raw comparator output
	input wire logic [1:0] mode_in, // Event mode select
	output logic level_out, // Synchronised comparator level
	output logic event_out // One-cycle selected event
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic evt;
	} cec_ed_state_t;

	cec_ed_state_t st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = raw_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.prev = st_ff.s2;
		case (mode_in)
			CEC_MODE_TOGGLE: nxt_st.evt = st_ff.s2 ^ st_ff.prev;
			CEC_MODE_FALL: nxt_st.evt = st_ff.prev & ~st_ff.s2;
			CEC_MODE_RISE: nxt_st.evt = ~st_ff.prev & st_ff.s2;
			CEC_MODE_RSVD: nxt_st.evt = 1'b0;
			default: nxt_st.evt = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_ff <= '0;
		end else if (clk_en_in) begin
			st_ff <= nxt_st;
		end
	end

	assign level_out = st_ff.s2;
	assign event_out = st_ff.evt;

	a_rise_event: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && mode_in == CEC_MODE_RISE && !st_ff.prev && st_ff.s2
		|=> event_out) else $error("rise event missed");
	a_rsvd_quiet: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && mode_in == CEC_MODE_RSVD |=> !event_out)
		else $error("reserved mode raised event");
endmodule : cec_edge_detect

// file: hw/cec_top.sv
// Purpose: Control and event logic around an on-chip voltage comparator
// Assumes: Host core I/O port at 8 bits, one access per enabled cycle
// Notes: Analog core is outside; this block drives its controls
// Overview of operation
// - Result is one when positive exceeds negative
// - Result bit 5 read-only, unlatched
// - Mode field: toggle, reserved, falling, rising
// - Matching transition sets event flag bit 4
// - Interrupt needs flag, enable and global enable
// - Interrupt line dedicated to comparator
// - Vector execution clears the flag
// - Writing one clears flag; zero keeps it
// - Power-off bit 7 removes comparator power
// - Bandgap select bit 6 replaces positive input
// - Bit 2 reads zero; bit 6 without variant
// - Reference on with brown-out or bandgap select
// - Negative input connected from first run edge after reset
`timescale 1ns/1ps
module cec_top
	import cec_pkg::*;
#(
	parameter bit HAS_BANDGAP = 1'b1
) (
	input wire logic clk_in, // System clock, 20 MHz
	input wire logic sys_rst_in, // Synchronous reset, high
	input wire logic clk_en_in, // Freezes all state when low
	input wire logic io_wr_in, // I/O write strobe
	input wire logic io_rd_in, // I/O read strobe
	input wire logic [5:0] io_addr_in, // I/O address
	input wire logic [7:0] io_wdata_in, // I/O write data
	output logic [7:0] io_rdata_out, // Registered read data
	input wire logic global_irq_en_in, // Status register global enable
	input wire logic irq_ack_in, // Vector taken for this source
	input wire logic comp_raw_in, // Analog comparator output
	input wire logic brown_out_enable_fuse_in, // Brown-out detector on
	output logic irq_out, // Dedicated comparator interrupt
	output logic comp_power_off_out, // Power down the comparator
	output logic bg_route_out, // Bandgap to positive input
	output logic ref_enable_out, // Internal reference power
	output logic neg_input_connect_out // Negative input connected
);
	typedef struct packed {
		cec_ctrl_t ctrl;
		logic [7:0] rdata;
		logic irq;
		logic pwr_off;
		logic bg_route;
		logic ref_en;
		logic neg_conn;
	} cec_state_t;

	cec_state_t st_ff, nxt_st;
	cec_bus_req_t req;
	logic result;
	logic evt;

	function automatic logic hit(input logic [5:0] a);
		hit = (a == CEC_CSR_ADDR);
	endfunction : hit

	assign req = '{wr: io_wr_in, rd: io_rd_in, addr: io_addr_in,
		wdata: io_wdata_in};

	cec_edge_detect u_edge (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.raw_in(comp_raw_in),
		.mode_in(st_ff.ctrl.mode),
		.level_out(result),
		.event_out(evt)
	);

	function automatic logic [7:0] csr_view(input cec_ctrl_t c,
		input logic res);
		logic [7:0] v;
		v = 8'h00;
		v[CEC_BIT_POWER_OFF] = c.power_off;
		v[CEC_BIT_BG_SEL] = HAS_BANDGAP ? c.bg_sel : 1'b0;
		v[CEC_BIT_RESULT] = res;
		v[CEC_BIT_FLAG] = c.flag;
		v[CEC_BIT_IRQ_EN] = c.irq_en;
		v[CEC_BIT_MODE_HI] = c.mode[1];
		v[CEC_BIT_MODE_LO] = c.mode[0];
		csr_view = v;
	endfunction : csr_view

	always_comb begin
		nxt_st = st_ff;
		if (req.wr && hit(req.addr)) begin
			nxt_st.ctrl.power_off = req.wdata[CEC_BIT_POWER_OFF];
			nxt_st.ctrl.bg_sel = HAS_BANDGAP & req.wdata[CEC_BIT_BG_SEL];
			nxt_st.ctrl.irq_en = req.wdata[CEC_BIT_IRQ_EN];
			nxt_st.ctrl.mode = {req.wdata[CEC_BIT_MODE_HI],
				req.wdata[CEC_BIT_MODE_LO]};
			if (req.wdata[CEC_BIT_FLAG]) begin
				nxt_st.ctrl.flag = 1'b0;
			end
		end
		if (irq_ack_in) begin
			nxt_st.ctrl.flag = 1'b0;
		end
		if (evt) begin
			nxt_st.ctrl.flag = 1'b1;
		end
		if (req.rd && hit(req.addr)) begin
			nxt_st.rdata = csr_view(st_ff.ctrl, result);
		end else begin
			nxt_st.rdata = 8'h00;
		end
		nxt_st.irq = nxt_st.ctrl.flag & nxt_st.ctrl.irq_en
			& global_irq_en_in;
		nxt_st.pwr_off = nxt_st.ctrl.power_off;
		nxt_st.bg_route = nxt_st.ctrl.bg_sel;
		nxt_st.ref_en = brown_out_enable_fuse_in
			| nxt_st.ctrl.bg_sel;
		nxt_st.neg_conn = 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			st_ff <= '0;
		end else if (clk_en_in) begin
			st_ff <= nxt_st;
		end
	end

	assign io_rdata_out = st_ff.rdata;
	assign irq_out = st_ff.irq;
	assign comp_power_off_out = st_ff.pwr_off;
	assign bg_route_out = st_ff.bg_route;
	assign ref_enable_out = st_ff.ref_en;
	assign neg_input_connect_out = st_ff.neg_conn;

	// Flag set by a matching event
	a_flag_set: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && evt |=> st_ff.ctrl.flag)
		else $error("event did not set flag");

	// Write one clears the flag
	a_flag_wclear: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && !evt && req.wr && hit(req.addr)
		&& req.wdata[CEC_BIT_FLAG] |=> !st_ff.ctrl.flag)
		else $error("write one did not clear flag");

	// Write zero keeps the flag
	a_flag_wkeep: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && st_ff.ctrl.flag && !irq_ack_in && req.wr
		&& !req.wdata[CEC_BIT_FLAG] |=> st_ff.ctrl.flag)
		else $error("write zero changed flag");

	// Flag holds without a clear source
	a_flag_hold: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && st_ff.ctrl.flag && !irq_ack_in
		&& !(req.wr && hit(req.addr) && req.wdata[CEC_BIT_FLAG])
		|=> st_ff.ctrl.flag)
		else $error("flag dropped on its own");

	// Vector taken clears the flag
	a_ack_clear: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && irq_ack_in && !evt |=> !st_ff.ctrl.flag)
		else $error("vector did not clear flag");

	// Request only with all enables
	a_irq_gate: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		irq_out && $past(clk_en_in) |-> st_ff.ctrl.flag
		&& st_ff.ctrl.irq_en && $past(global_irq_en_in))
		else $error("interrupt without all enables");

	// Request raised once all enables stand
	a_irq_set: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && st_ff.ctrl.flag && st_ff.ctrl.irq_en
		&& global_irq_en_in && !irq_ack_in
		&& !(req.wr && hit(req.addr)) |=> irq_out)
		else $error("interrupt not raised");

	// Result bit taken from the synchronised level
	a_rd_result: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && req.rd && hit(req.addr)
		|=> io_rdata_out[CEC_BIT_RESULT] == $past(result)
		&& io_rdata_out[CEC_BIT_RSVD] == 1'b0)
		else $error("read view wrong");

	// Reserved bits read zero
	a_rsvd_zero: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && req.rd && hit(req.addr)
		|=> io_rdata_out[CEC_BIT_RSVD] == 1'b0
		&& (HAS_BANDGAP || io_rdata_out[CEC_BIT_BG_SEL] == 1'b0))
		else $error("reserved bit set");

	// Read port idles at zero
	a_rd_idle: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && !(req.rd && hit(req.addr))
		|=> io_rdata_out == 8'h00)
		else $error("read data not idle");

	// Reference power follows fuse or select
	a_ref_power: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		ref_enable_out == ($past(brown_out_enable_fuse_in)
		|| st_ff.ctrl.bg_sel) || !$past(clk_en_in))
		else $error("reference power wrong");

	// Control outputs follow the fields
	a_pwr_follow: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		comp_power_off_out == st_ff.ctrl.power_off
		&& bg_route_out == st_ff.ctrl.bg_sel)
		else $error("power or route mismatch");

	// Written fields land on the next edge
	a_wr_fields: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		clk_en_in && req.wr && hit(req.addr)
		|=> comp_power_off_out == $past(req.wdata[CEC_BIT_POWER_OFF])
		&& st_ff.ctrl.mode == $past(req.wdata[1:0]))
		else $error("written field lost");

	// Negative input attached after first run edge
	a_neg_conn: assert property (@(posedge clk_in)
		disable iff (sys_rst_in)
		$past(clk_en_in) && !$past(sys_rst_in)
		|-> neg_input_connect_out)
		else $error("negative input detached");
endmodule : cec_top

// file: sim/cec_comp_model.sv
// Purpose: Behavioural analog comparator core and its input pins
// Assumes: Pin voltages given in millivolts by the bench
// Notes: Output stays low while powered down
`timescale 1ns/1ps
module cec_comp_model #(
	parameter logic [11:0] BG_MV = 12'h4C4
) (
	input wire logic power_off_in, // Comparator powered down
	input wire logic bg_route_in, // Bandgap replaces positive pin
	input wire logic neg_connect_in, // Negative pin connected
	input wire logic [11:0] pos_mv_in, // Positive pin voltage
	input wire logic [11:0] neg_mv_in, // Negative pin voltage
	output logic raw_out // Comparator decision
);
	logic [11:0] pos_mv;
	assign pos_mv = bg_route_in ? BG_MV : pos_mv_in;
	// Decision only with power on and negative pin attached
	assign raw_out = !power_off_in && neg_connect_in
		&& (pos_mv > neg_mv_in);
endmodule : cec_comp_model

// file: sim/cec_top_test.sv
// Purpose: Self-checking bench for the comparator event control block
// Assumes: Register at 0x08, flag sets 4 edges after input change
// Notes: Analog side is the behavioural comparator model
`timescale 1ns/1ps
module cec_top_test
	import cec_pkg::*;
;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic io_wr_in = 1'b0;
	logic io_rd_in = 1'b0;
	logic [5:0] io_addr_in = CEC_CSR_ADDR;
	logic [7:0] io_wdata_in = 8'h00;
	logic global_irq_en_in = 1'b0;
	logic irq_ack_in = 1'b0;
	logic fuse = 1'b0;
	logic clk_en = 1'b1;
	logic [11:0] pos_mv = 12'h064;
	logic [11:0] neg_mv = 12'h1F4;
	logic [7:0] io_rdata_out, rd_val;
	logic irq_out, poff, bg, refen, negc, raw;
	int failures = 0;
	int cmp_count = 0;

	cec_top #(.HAS_BANDGAP(1'b1)) u_dut (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .clk_en_in(clk_en), .io_wr_in(io_wr_in),
		.io_rd_in(io_rd_in), .io_addr_in(io_addr_in),
		.io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
		.global_irq_en_in(global_irq_en_in), .irq_ack_in(irq_ack_in),
		.comp_raw_in(raw), .brown_out_enable_fuse_in(fuse),
		.irq_out(irq_out), .comp_power_off_out(poff), .bg_route_out(bg),
		.ref_enable_out(refen), .neg_input_connect_out(negc));
	cec_comp_model u_model (.power_off_in(poff), .bg_route_in(bg),
		.neg_connect_in(negc), .pos_mv_in(pos_mv), .neg_mv_in(neg_mv),
		.raw_out(raw));

	initial begin
		forever #25 clk_in = ~clk_in;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc

	// One register access; read data lands in rd_val
	task automatic acc(input logic w, input logic [5:0] a,
		input logic [7:0] d);
		@(posedge clk_in);
		io_wr_in <= w;
		io_rd_in <= !w;
		io_addr_in <= a;
		io_wdata_in <= d;
		@(posedge clk_in);
		io_wr_in <= 1'b0;
		io_rd_in <= 1'b0;
		#1 rd_val = io_rdata_out;
	endtask : acc

	// Move the positive pin, then let the synchroniser settle
	task automatic vin(input logic [11:0] p);
		@(posedge clk_in);
		pos_mv <= p;
		cyc(6);
	endtask : vin

	task automatic t_reset();
		acc(1'b0, CEC_CSR_ADDR, 8'h00);
		chk(rd_val, 8'h00);
		acc(1'b1, 6'h09, 8'hFF);
		acc(1'b0, 6'h09, 8'h00);
		chk(rd_val, 8'h00);
		acc(1'b0, CEC_CSR_ADDR, 8'h00);
		chk(rd_val, 8'h00);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_modes();
		logic [3:0] on_rise;
		logic [3:0] on_fall;
		on_rise = 4'h9;
		on_fall = 4'h5;
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, CEC_CSR_ADDR, 8'h10 | 8'(i));
			vin(12'h384);
			acc(1'b0, CEC_CSR_ADDR, 8'h00);
			chk(rd_val[4], on_rise[i]);
			chk(rd_val[5], 1'b1);
			acc(1'b1, CEC_CSR_ADDR, 8'h10 | 8'(i));
			vin(12'h064);
			acc(1'b0, CEC_CSR_ADDR, 8'h00);
			chk(rd_val[4], on_fall[i]);
		end
		$display("t_modes done");
	endtask : t_modes

	task automatic t_irq();
		acc(1'b1, CEC_CSR_ADDR, 8'h1B);
		global_irq_en_in <= 1'b1;
		vin(12'h384);
		chk(irq_out, 1'b1);
		@(posedge clk_in);
		irq_ack_in <= 1'b1;
		@(posedge clk_in);
		irq_ack_in <= 1'b0;
		cyc(2);
		chk(irq_out, 1'b0);
		vin(12'h064);
		vin(12'h384);
		acc(1'b1, CEC_CSR_ADDR, 8'h0B);
		acc(1'b0, CEC_CSR_ADDR, 8'h00);
		chk(rd_val, 8'h3B);
		global_irq_en_in <= 1'b0;
		cyc(3);
		chk(irq_out, 1'b0);
		acc(1'b1, CEC_CSR_ADDR, 8'h1B);
		acc(1'b0, CEC_CSR_ADDR, 8'h00);
		chk(rd_val, 8'h2B);
		$display("t_irq done");
	endtask : t_irq

	task automatic t_ctrl();
		vin(12'h064);
		acc(1'b1, CEC_CSR_ADDR, 8'hD4);
		cyc(6);
		chk({poff, bg, refen, negc}, 4'hF);
		acc(1'b0, CEC_CSR_ADDR, 8'h00);
		chk(rd_val, 8'hC0);
		acc(1'b1, CEC_CSR_ADDR, 8'h50);
		cyc(6);
		acc(1'b0, CEC_CSR_ADDR, 8'h00);
		chk(rd_val, 8'h70);
		acc(1'b1, CEC_CSR_ADDR, 8'h10);
		fuse <= 1'b1;
		cyc(3);
		chk(refen, 1'b1);
		fuse <= 1'b0;
		cyc(3);
		chk(refen, 1'b0);
		// Frozen clock enable must drop the write
		clk_en <= 1'b0;
		acc(1'b1, CEC_CSR_ADDR, 8'h80);
		clk_en <= 1'b1;
		acc(1'b0, CEC_CSR_ADDR, 8'h00);
		chk(rd_val, 8'h10);
		$display("t_ctrl done");
	endtask : t_ctrl

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	initial begin
		cyc(2);
		sys_rst_in <= 1'b0;
		t_reset();
		t_modes();
		t_irq();
		t_ctrl();
		give_verdict();
	end

	initial begin
		cyc(3000);
		failures++;
		give_verdict();
	end
endmodule : cec_top_test
